// ===== logic/dcc_pkg.sv
package dcc_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int NUM_CMP = 2;
	// Register offsets
	localparam logic [2:0] OFS_CTRL_A = 3'h0;
	localparam logic [2:0] OFS_CTRL_B = 3'h1;
	localparam logic [2:0] OFS_IRQ_STATUS = 3'h2;
	localparam logic [2:0] OFS_IRQ_CLEAR = 3'h3;
	localparam logic [2:0] OFS_IRQ_ENABLE = 3'h4;
	localparam logic [2:0] OFS_IRQ_SET = 3'h5;
	// Control register fields
	localparam int BIT_ON = 6;
	localparam int BIT_INVERT = 5;
	localparam int BIT_RESULT = 4;
	localparam int BIT_HYS = 0;
	localparam logic RST_ON = 1'b0;
	localparam logic RST_INVERT = 1'b0;
	localparam logic RST_RESULT = 1'b0;
	localparam logic RST_HYS = 1'b1;
	localparam logic [1:0] RST_IRQ = 2'h0;

	typedef struct packed {
		logic on;
		logic invert;
		logic hys;
	} dcc_ctrl_s;

	localparam dcc_ctrl_s RST_CTRL = '{RST_ON, RST_INVERT, RST_HYS};

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} dcc_bus_s;
endpackage

// ===== logic/dcc_channel.sv
`timescale 1ns/1ps
module dcc_channel
	import dcc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic raw,
	input wire dcc_pkg::dcc_ctrl_s ctrl,
	output logic result,
	output logic changed
);
	import dcc_pkg::*;

	logic s1, s2, s3, filt;
	logic next_filt, next_result, next_changed;

	// Edge taken only once stage two and three agree
	always_comb begin
		next_filt = (s2 == s3) ? s3 : filt;
		next_result = ctrl.on & (next_filt ^ ctrl.invert);
		next_changed = next_result != result;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			filt <= 1'b0;
			result <= RST_RESULT;
			changed <= 1'b0;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			filt <= next_filt;
			result <= next_result;
			changed <= next_changed;
		end
	end

	a_off_result_low: assert property (
		@(posedge clock) disable iff (!rst_n)
		!ctrl.on |=> !result)
		else $error("result high while comparator off");

	a_polarity_map: assert property (
		@(posedge clock) disable iff (!rst_n)
		(ctrl.on && s2 == s3) |=> result == ($past(s3) ^ $past(ctrl.invert)))
		else $error("result does not follow input and polarity");

	a_change_pulse: assert property (
		@(posedge clock) disable iff (!rst_n)
		changed |-> result != $past(result))
		else $error("change pulse without result change");
endmodule // dcc_channel

// ===== logic/dcc_top.sv
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - Two comparators, each with its own identical control register.
// - Bit 6 switches comparator on; off gives no power; resets 0.
// - Bit 5 inverts result when 1, passes unchanged when 0; resets 0.
// - Bit 4 reads-only polarity-adjusted result; resets 0.
// - Bit 0 enables hysteresis feedback; resets 1.
// - Bits 7 and 3 to 1 ignore writes and read zero.
// - Result change sets own flag; enabled flag raises interrupt.
// - Flags follow the register result bit, not the pin.
// - In sleep, an enabled comparator's flag setting also wakes device.
// - Enabled comparator keeps working during sleep or idle.
// - Enabled comparator disconnects pull-highs on its input pins.
// - While enabled, port reads give zero if direction 1, else data.
// - Result stored in register and routed to its own bit of cmp_pin_out.
module dcc_top
	import dcc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [dcc_pkg::ADDR_W-1:0] addr,
	input wire logic [dcc_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [dcc_pkg::DATA_W-1:0] rdata,
	input wire logic cmp_a_raw,
	input wire logic cmp_b_raw,
	input wire logic sleep_mode,
	input wire logic [1:0] port_dir,
	input wire logic [1:0] port_data,
	input wire logic [1:0] port_normal,
	output logic [1:0] port_read,
	output logic cmp_a_on,
	output logic cmp_b_on,
	output logic cmp_a_hysteresis_on,
	output logic cmp_b_hysteresis_on,
	output logic [1:0] pullup_off,
	output logic [1:0] cmp_pin_out,
	output logic irq,
	output logic wake
);
	import dcc_pkg::*;

	dcc_bus_s bus;
	dcc_ctrl_s ctrl [NUM_CMP];
	dcc_ctrl_s next_ctrl [NUM_CMP];
	logic [1:0] result;
	logic [1:0] ev;
	logic [1:0] on_vec;
	logic [1:0] status, next_status;
	logic [1:0] enable, next_enable;
	logic next_irq, next_wake;
	logic [DATA_W-1:0] next_rdata;
	logic [1:0] next_port_read;
	logic [1:0] next_pullup_off;
	logic [1:0] next_pin_out;
	logic next_a_on, next_b_on, next_a_hys, next_b_hys;

	assign bus = '{wr, rd, addr, wdata};
	assign on_vec = {ctrl[1].on, ctrl[0].on};

	// One channel per comparator, sharing one register layout
	dcc_channel u_cmp_a (
		.clock(clock),
		.rst_n(rst_n),
		.raw(cmp_a_raw),
		.ctrl(ctrl[0]),
		.result(result[0]),
		.changed(ev[0])
	);

	dcc_channel u_cmp_b (
		.clock(clock),
		.rst_n(rst_n),
		.raw(cmp_b_raw),
		.ctrl(ctrl[1]),
		.result(result[1]),
		.changed(ev[1])
	);

	// Control registers
	always_comb begin
		for (int i = 0; i < NUM_CMP; i++) begin
			next_ctrl[i] = ctrl[i];
			if (bus.wr && bus.addr == (i == 0 ? OFS_CTRL_A : OFS_CTRL_B)) begin
				next_ctrl[i].on = bus.wdata[BIT_ON];
				next_ctrl[i].invert = bus.wdata[BIT_INVERT];
				next_ctrl[i].hys = bus.wdata[BIT_HYS];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl[0] <= RST_CTRL;
			ctrl[1] <= RST_CTRL;
		end else begin
			ctrl[0] <= next_ctrl[0];
			ctrl[1] <= next_ctrl[1];
		end
	end

	// Interrupt flags; a new change beats a clear in the same cycle
	always_comb begin
		next_status = status;
		next_enable = enable;
		if (bus.wr && bus.addr == OFS_IRQ_CLEAR)
			next_status = next_status & ~bus.wdata[1:0];
		if (bus.wr && bus.addr == OFS_IRQ_SET)
			next_status = next_status | bus.wdata[1:0];
		if (bus.wr && bus.addr == OFS_IRQ_ENABLE)
			next_enable = bus.wdata[1:0];
		next_status = next_status | ev;
		next_irq = |(next_status & next_enable);
		// Wake only on a flag that was still clear
		next_wake = sleep_mode & |(ev & on_vec & ~status);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status <= RST_IRQ;
			enable <= RST_IRQ;
			irq <= 1'b0;
			wake <= 1'b0;
		end else begin
			status <= next_status;
			enable <= next_enable;
			irq <= next_irq;
			wake <= next_wake;
		end
	end

	// Read port
	function automatic logic [DATA_W-1:0] ctrl_word(dcc_ctrl_s c,
			logic res);
		logic [DATA_W-1:0] w;
		w = '0;
		w[BIT_ON] = c.on;
		w[BIT_INVERT] = c.invert;
		w[BIT_RESULT] = res;
		w[BIT_HYS] = c.hys;
		return w;
	endfunction

	always_comb begin
		next_rdata = '0;
		if (bus.rd) begin
			case (bus.addr)
				OFS_CTRL_A: next_rdata = ctrl_word(ctrl[0], result[0]);
				OFS_CTRL_B: next_rdata = ctrl_word(ctrl[1], result[1]);
				OFS_IRQ_STATUS: next_rdata = {6'h00, status};
				OFS_IRQ_ENABLE: next_rdata = {6'h00, enable};
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			rdata <= 8'h00;
		else
			rdata <= next_rdata;
	end

	// Pin side: power, hysteresis, pull-highs, port reads, result pin
	always_comb begin
		next_a_on = next_ctrl[0].on;
		next_b_on = next_ctrl[1].on;
		next_a_hys = next_ctrl[0].hys;
		next_b_hys = next_ctrl[1].hys;
		next_pullup_off = {next_ctrl[1].on, next_ctrl[0].on};
		next_pin_out = result;
		for (int i = 0; i < NUM_CMP; i++)
			next_port_read[i] = on_vec[i] ?
				(!port_dir[i] & port_data[i]) : port_normal[i];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmp_a_on <= RST_ON;
			cmp_b_on <= RST_ON;
			cmp_a_hysteresis_on <= RST_HYS;
			cmp_b_hysteresis_on <= RST_HYS;
			pullup_off <= 2'h0;
			cmp_pin_out <= 2'h0;
			port_read <= 2'h0;
		end else begin
			cmp_a_on <= next_a_on;
			cmp_b_on <= next_b_on;
			cmp_a_hysteresis_on <= next_a_hys;
			cmp_b_hysteresis_on <= next_b_hys;
			pullup_off <= next_pullup_off;
			cmp_pin_out <= next_pin_out;
			port_read <= next_port_read;
		end
	end

	a_reserved_zero: assert property (
		@(posedge clock) disable iff (!rst_n)
		(rd && (addr == OFS_CTRL_A || addr == OFS_CTRL_B))
		|=> rdata[7] == 1'b0 && rdata[3:1] == 3'h0)
		else $error("reserved control bits read nonzero");

	a_on_write: assert property (
		@(posedge clock) disable iff (!rst_n)
		(wr && addr == OFS_CTRL_A) |=> cmp_a_on == $past(wdata[BIT_ON]))
		else $error("on bit not taken from write");

	a_hys_write: assert property (
		@(posedge clock) disable iff (!rst_n)
		(wr && addr == OFS_CTRL_B)
		|=> cmp_b_hysteresis_on == $past(wdata[BIT_HYS]))
		else $error("hysteresis bit not taken from write");

	a_flag_set: assert property (
		@(posedge clock) disable iff (!rst_n)
		ev[0] |=> status[0])
		else $error("change did not set flag");

	a_set_beats_clear: assert property (
		@(posedge clock) disable iff (!rst_n)
		(ev[1] && wr && addr == OFS_IRQ_CLEAR && wdata[1]) |=> status[1])
		else $error("clear beat a new change");

	a_irq_level: assert property (
		@(posedge clock) disable iff (!rst_n)
		irq == |(status & enable))
		else $error("interrupt not matching flags and enables");

	a_wake_cause: assert property (
		@(posedge clock) disable iff (!rst_n)
		wake |-> $past(sleep_mode) && $past(|(ev & ~status)))
		else $error("wake without sleep and fresh flag");

	a_pullup_off: assert property (
		@(posedge clock) disable iff (!rst_n)
		pullup_off == on_vec)
		else $error("pull-high state not following enable");

	a_port_read: assert property (
		@(posedge clock) disable iff (!rst_n)
		(on_vec[0] && port_dir[0]) |=> !port_read[0])
		else $error("port read not zero while comparator on");

	a_result_read: assert property (
		@(posedge clock) disable iff (!rst_n)
		(rd && addr == OFS_CTRL_A) |=> rdata[BIT_RESULT] == $past(result[0]))
		else $error("result bit read wrong");

	a_on_write_b: assert property (
		@(posedge clock) disable iff (!rst_n)
		(wr && addr == OFS_CTRL_B) |=> cmp_b_on == $past(wdata[BIT_ON]))
		else $error("second on bit not taken from write");

	a_hys_write_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		(wr && addr == OFS_CTRL_A)
		|=> cmp_a_hysteresis_on == $past(wdata[BIT_HYS]))
		else $error("first hysteresis bit not taken from write");

	a_invert_write: assert property (
		@(posedge clock) disable iff (!rst_n)
		(wr && addr == OFS_CTRL_A)
		|=> ctrl[0].invert == $past(wdata[BIT_INVERT]))
		else $error("polarity bit not taken from write");

	a_ctrl_hold: assert property (
		@(posedge clock) disable iff (!rst_n)
		!(wr && addr == OFS_CTRL_B) |=> $stable(ctrl[1]))
		else $error("control register changed without its write");

	a_result_read_b: assert property (
		@(posedge clock) disable iff (!rst_n)
		(rd && addr == OFS_CTRL_B)
		|=> rdata[BIT_RESULT] == $past(result[1]))
		else $error("second result bit read wrong");

	a_status_read: assert property (
		@(posedge clock) disable iff (!rst_n)
		(rd && addr == OFS_IRQ_STATUS)
		|=> rdata == {6'h00, $past(status)})
		else $error("flag register read wrong");

	a_enable_write: assert property (
		@(posedge clock) disable iff (!rst_n)
		(wr && addr == OFS_IRQ_ENABLE)
		|=> enable == $past(wdata[1:0]))
		else $error("enable register not taken from write");

	a_flag_set_b: assert property (
		@(posedge clock) disable iff (!rst_n)
		ev[1] |=> status[1])
		else $error("second change did not set flag");

	a_flag_sticky: assert property (
		@(posedge clock) disable iff (!rst_n)
		(status[0] && !(wr && addr == OFS_IRQ_CLEAR && wdata[0]))
		|=> status[0])
		else $error("flag dropped without a clear");

	a_flag_clear: assert property (
		@(posedge clock) disable iff (!rst_n)
		(wr && addr == OFS_IRQ_CLEAR && wdata[1] && !ev[1])
		|=> !status[1])
		else $error("flag not cleared by write");

	a_flag_cause: assert property (
		@(posedge clock) disable iff (!rst_n)
		$rose(status[0]) |-> $past(ev[0])
			|| $past(wr && addr == OFS_IRQ_SET && wdata[0]))
		else $error("flag set without a result change");

	a_flag_write_set: assert property (
		@(posedge clock) disable iff (!rst_n)
		(wr && addr == OFS_IRQ_SET && wdata[1]) |=> status[1])
		else $error("flag not set by software");

	a_wake_fresh: assert property (
		@(posedge clock) disable iff (!rst_n)
		(sleep_mode && ev[0] && on_vec[0] && !status[0]) |=> wake)
		else $error("missed wake on fresh flag");

	a_wake_awake: assert property (
		@(posedge clock) disable iff (!rst_n)
		!sleep_mode |=> !wake)
		else $error("wake while not asleep");

	a_wake_blocked: assert property (
		@(posedge clock) disable iff (!rst_n)
		(&status) |=> !wake)
		else $error("wake although both flags were set");

	a_port_read_b: assert property (
		@(posedge clock) disable iff (!rst_n)
		(on_vec[1] && port_dir[1]) |=> !port_read[1])
		else $error("second port read not zero while on");

	a_port_data: assert property (
		@(posedge clock) disable iff (!rst_n)
		(on_vec[0] && !port_dir[0])
		|=> port_read[0] == $past(port_data[0]))
		else $error("port read not data register value");

	a_port_normal: assert property (
		@(posedge clock) disable iff (!rst_n)
		!on_vec[1] |=> port_read[1] == $past(port_normal[1]))
		else $error("port read wrong while comparator off");

	a_pin_follow: assert property (
		@(posedge clock) disable iff (!rst_n)
		cmp_pin_out == $past(result))
		else $error("result pin not following result bit");

	a_hys_follow: assert property (
		@(posedge clock) disable iff (!rst_n)
		cmp_a_hysteresis_on == ctrl[0].hys)
		else $error("hysteresis output not following register");
endmodule // dcc_top

// ===== verification/dcc_analog_model.sv
`timescale 1ns/1ps
module dcc_analog_model (
	input wire logic on_a,
	input wire logic on_b,
	input wire logic [15:0] pos_a,
	input wire logic [15:0] neg_a,
	input wire logic [15:0] pos_b,
	input wire logic [15:0] neg_b,
	output logic raw_a,
	output logic raw_b
);
	// Unpowered stage has no valid decision: show the opposite level
	assign raw_a = on_a ? (pos_a > neg_a) : (pos_a <= neg_a);
	assign raw_b = on_b ? (pos_b > neg_b) : (pos_b <= neg_b);
endmodule // dcc_analog_model

// ===== verification/dual_comparator_control_tb.sv
`timescale 1ns/1ps
module dual_comparator_control_tb;
	import dcc_pkg::*;
	logic clock = 0;
	logic rst_n = 0;
	logic [2:0] addr = '0;
	logic [7:0] wdata = '0;
	logic wr = 0;
	logic rd = 0;
	logic sleep_mode = 0;
	logic [1:0] port_dir = '0;
	logic [1:0] port_data = '0;
	logic [1:0] port_normal = '0;
	logic [1:0][15:0] pos = '0;
	logic [1:0][15:0] neg = '0;
	logic [7:0] rdata;
	logic [1:0] port_read, pullup_off, cmp_pin_out;
	logic a_raw, b_raw, a_on, b_on, a_hys, b_hys, irq, wake;
	logic [2:0] ca;
	int errors = 0;
	int checked = 0;
	int wakes = 0;
	int base;

	initial begin
		forever #5 clock = ~clock;
	end

	// Wake is a one-cycle pulse, so count it every edge
	always @(posedge clock) begin
		if (wake === 1'b1) wakes++;
	end

	dcc_top dut(.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .cmp_a_raw(a_raw),
		.cmp_b_raw(b_raw), .sleep_mode(sleep_mode), .port_dir(port_dir),
		.port_data(port_data), .port_normal(port_normal),
		.port_read(port_read), .cmp_a_on(a_on), .cmp_b_on(b_on),
		.cmp_a_hysteresis_on(a_hys), .cmp_b_hysteresis_on(b_hys),
		.pullup_off(pullup_off), .cmp_pin_out(cmp_pin_out), .irq(irq),
		.wake(wake));

	dcc_analog_model model(.on_a(a_on), .on_b(b_on), .pos_a(pos[0]),
		.neg_a(neg[0]), .pos_b(pos[1]), .neg_b(neg[1]), .raw_a(a_raw),
		.raw_b(b_raw));

	task check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task rchk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask

	// Allows for the synchroniser and filter before the result bit
	task volt(input int i, input logic hi);
		@(posedge clock);
		pos[i] <= hi ? 16'h0200 : 16'h0100;
		neg[i] <= 16'h0180;
		repeat (10) @(posedge clock);
	endtask

	task final_report;
		$display("Mismatches %0d, comparisons %0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		final_report;
	end

	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		rchk(OFS_CTRL_A, 8'h01);
		rchk(OFS_CTRL_B, 8'h01);
		rchk(OFS_IRQ_STATUS, 8'h00);
		wreg(3'h7, 8'hFF);
		rchk(3'h7, 8'h00);
		check({6'h0, b_hys, a_hys}, 8'h03);
		for (int i = 0; i < 2; i++) begin
			ca = 3'(i);
			volt(i, 1'b0);
			wreg(ca, 8'hFF);
			repeat (10) @(posedge clock);
			rchk(ca, 8'h71);
			check({6'h0, pullup_off[i], cmp_pin_out[i]}, 8'h03);
			wreg(ca, 8'h40);
			repeat (10) @(posedge clock);
			wreg(OFS_IRQ_CLEAR, 8'h03);
			wreg(OFS_IRQ_ENABLE, 8'h03);
			rchk(OFS_IRQ_ENABLE, 8'h03);
			check({7'h0, irq}, 8'h00);
			volt(i, 1'b1);
			rchk(ca, 8'h50);
			rchk(OFS_IRQ_STATUS, 8'h01 << i);
			check({7'h0, irq}, 8'h01);
			wreg(OFS_IRQ_CLEAR, 8'h03);
			wreg(OFS_IRQ_ENABLE, 8'h00);
			volt(i, 1'b0);
			rchk(OFS_IRQ_STATUS, 8'h01 << i);
			check({7'h0, irq}, 8'h00);
			wreg(OFS_IRQ_CLEAR, 8'h03);
			sleep_mode <= 1'b1;
			base = wakes;
			volt(i, 1'b1);
			rchk(ca, 8'h50);
			check(8'(wakes - base), 8'h01);
			wreg(OFS_IRQ_SET, 8'h01 << i);
			volt(i, 1'b0);
			check(8'(wakes - base), 8'h01);
			sleep_mode <= 1'b0;
			wreg(ca, 8'h00);
			rchk(ca, 8'h00);
			check({7'h0, pullup_off[i]}, 8'h00);
		end
		wreg(OFS_CTRL_A, 8'h41);
		port_dir <= 2'h1;
		port_data <= 2'h1;
		port_normal <= 2'h2;
		repeat (3) @(posedge clock);
		#1 check({6'h0, port_read}, 8'h02);
		@(posedge clock);
		port_dir <= 2'h0;
		repeat (3) @(posedge clock);
		#1 check({6'h0, port_read}, 8'h03);
		final_report;
	end
endmodule // dual_comparator_control_tb
